// ===== shared/sysacc_consts.svh
`ifndef SYSACC_CONSTS_SVH
`define SYSACC_CONSTS_SVH

// register offsets on the debug link register port
`define OFS_RESET_REQ      4'h8
`define OFS_CLOCK_CTRL     4'h9
`define OFS_ACCESS_CTRL    4'ha
`define OFS_ACCESS_STATUS  4'hb
`define OFS_CRC_STATUS     4'hc

// reset request codes
`define RESET_CODE         8'h59
`define RUN_CODE           8'h00

// reset values
`define RST_RESET_REQ      8'h00
`define RST_CLOCK_CTRL     2'h3
`define RST_LOCK           1'h1

// status register bit positions
`define ST_BOOT_OR_FAIL    7
`define ST_ERASE_FAILED    6
`define ST_RESET_ACTIVE    5
`define ST_IN_SLEEP        4
`define ST_PROG_START      3
`define ST_UROW_START      2
`define ST_BOOT_DONE       1
`define ST_LOCK            0

// control register bit positions
`define CT_USER_ROW_DONE   1
`define CT_CLOCK_REQUEST   0

`endif

// ===== shared/sysacc_pkg.sv
package sysacc_pkg;

	// crc status field, one-hot
	typedef enum logic [2:0] {
		CRC_OFF  = 3'h0,
		CRC_BUSY = 3'h1,
		CRC_OK   = 3'h2,
		CRC_FAIL = 3'h4
	} crc_state_e;

	// divider select for the port clock
	typedef logic [1:0] clk_sel_t;

endpackage

// ===== hdl/sync_bit.sv
`timescale 1ns/1ns
`default_nettype none

// three-stage synchroniser with agreement on the last two stages
module sync_bit (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      sync_out
);

	typedef struct packed {
		logic [2:0] stage;
		logic       value;
	} sync_s;

	sync_s state_q;
	sync_s state_d;

	// stage 0 is read only by stage 1
	always_comb begin
		state_d = state_q;
		state_d.stage = {state_q.stage[1:0], async_in};
		if (state_q.stage[1] == state_q.stage[2]) begin
			state_d.value = state_q.stage[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign sync_out = state_q.value;

endmodule

`default_nettype wire

// ===== hdl/system_access_regs.sv
// Contract
// (RULE1) writing 0x59 to reset request asserts system reset; 0x00 clears; others reserved
// (RULE2) system reset held while register holds reset code, released on clear code
// (RULE3) system reset from the register never resets this port logic
// (RULE4) divider select 1,2,3 give 16, 8, 4 MHz; 0 reserved
// (RULE5) divider select resets to the 4 MHz setting, register reads 0x03
// (RULE6) writing one to user-row-done starts user row flash programming
// (RULE7) user-row-done writes accepted only after user-row key decoded
// (RULE8) debugger writes user row data to ram before user-row-done
// (RULE9) clock request bit high requests system clock regardless of sleep
// (RULE10) clock request bit set automatically whenever the port becomes enabled
// (RULE11) status bit 7 is erase-failed OR boot-done
// (RULE12) erase-failed sets on failed erase, clears on any reset incl. requested
// (RULE13) reset-active reads one during system reset, clears on read
// (RULE14) in-sleep reads one while system idles or sleeps deeper
// (RULE15) programming-start reads one once memory programming may begin
// (RULE16) debugger resets system through reset request after programming
// (RULE17) user-row-start reads one once user row programming may begin
// (RULE18) boot-done sets at end of boot; bus access denied until then
// (RULE19) debugger checks boot-done one and reset-active zero before bus access
// (RULE20) lock flag resets to one, reads zero after erase clearing lock bits
// (RULE21) crc status one-hot: 0 off, 1 busy, 2 good, 4 failed
// (RULE22) registers reached only through the debug link instruction port
// (RULE23) programming key flag clears when programming starts
`timescale 1ns/1ns
`default_nettype none
`include "sysacc_consts.svh"

module system_access_regs
	import sysacc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       port_enable,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       urow_key_ok,
	input  wire logic       prog_key_set,
	input  wire logic       sys_reset_in,
	input  wire logic       sys_sleep_in,
	input  wire logic       boot_done_in,
	input  wire logic       erase_fail_ev,
	input  wire logic       erase_unlock_ev,
	input  wire logic       prog_start_in,
	input  wire logic       urow_start_in,
	input  wire logic [2:0] crc_status_in,
	output logic [7:0]      reg_rdata,
	output logic            system_reset_req,
	output logic            system_clock_request,
	output logic            user_row_done,
	output logic [1:0]      port_clock_divider_select,
	output logic            bus_access_allowed,
	output logic            memory_programming_key_flag
);

	typedef struct packed {
		logic [7:0] reset_req;
		clk_sel_t   clk_sel;
		logic       clk_req;
		logic       urow_done;
		logic       erase_failed;
		logic       reset_seen;
		logic       lock;
		logic       enable_prev;
		logic       prog_key;
		logic [7:0] rdata;
		logic       bus_ok;
		logic       reset_out;
	} regs_s;

	regs_s state_q;
	regs_s state_d;

	logic       sleep_s;
	logic       system_reset_active_s;
	logic       boot_s;
	logic       pstart_s;
	logic       ustart_s;
	logic       held_reset;
	logic [7:0] status_w;

	// system-side levels come from another domain
	// a level is believed only once two stages agree, so one-sample glitches on these levels never reach status
	sync_bit u_sync_sleep (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (sys_sleep_in),
		.sync_out (sleep_s)
	);
	sync_bit u_sync_rst (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (sys_reset_in),
		.sync_out (system_reset_active_s)
	);
	sync_bit u_sync_boot (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (boot_done_in),
		.sync_out (boot_s)
	);
	sync_bit u_sync_pst (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (prog_start_in),
		.sync_out (pstart_s)
	);
	sync_bit u_sync_ust (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (urow_start_in),
		.sync_out (ustart_s)
	);

	// the register-held reset counts as system reset too
	assign held_reset = state_q.reset_out;

	// status assembly
	always_comb begin
		status_w = 8'h00;
		// (RULE11) bit 7 combine
		status_w[`ST_BOOT_OR_FAIL] = state_q.erase_failed | boot_s;
		status_w[`ST_ERASE_FAILED] = state_q.erase_failed;
		status_w[`ST_RESET_ACTIVE] = state_q.reset_seen;
		// (RULE14) sleep level
		status_w[`ST_IN_SLEEP]     = sleep_s;
		// (RULE15) programming start
		status_w[`ST_PROG_START]   = pstart_s;
		// (RULE17) user row start
		status_w[`ST_UROW_START]   = ustart_s;
		status_w[`ST_BOOT_DONE]    = boot_s;
		status_w[`ST_LOCK]         = state_q.lock;
	end

	// next state; the system reset only clears erase_failed and bus_ok and sets reset_seen here, never the configuration
	always_comb begin
		state_d = state_q;
		state_d.enable_prev = port_enable;
		state_d.urow_done = 1'b0;

		// (RULE1) reset request codes
		if (reg_wr && reg_addr == `OFS_RESET_REQ) begin
			state_d.reset_req = reg_wdata;
		end
		// (RULE2) registered copy so the reset pin never glitches on a compare
		state_d.reset_out = (state_d.reset_req == `RESET_CODE);
		// (RULE4) divider select, reserved code kept out
		if (reg_wr && reg_addr == `OFS_CLOCK_CTRL && reg_wdata[1:0] != 2'h0) begin
			state_d.clk_sel = reg_wdata[1:0];
		end
		if (reg_wr && reg_addr == `OFS_ACCESS_CTRL) begin
			// (RULE9) clock request write
			state_d.clk_req = reg_wdata[`CT_CLOCK_REQUEST];
			// (RULE7) key gated start
			if (urow_key_ok) begin
				// (RULE6) start pulse
				state_d.urow_done = reg_wdata[`CT_USER_ROW_DONE];
			end
		end
		// (RULE10) auto request on enable
		if (port_enable && !state_q.enable_prev) begin
			state_d.clk_req = 1'b1;
			// (RULE5) default divider after enable
			state_d.clk_sel = `RST_CLOCK_CTRL;
		end

		// (RULE12) erase fail, set wins
		if (system_reset_active_s || held_reset) begin
			state_d.erase_failed = 1'b0;
		end
		if (erase_fail_ev) begin
			state_d.erase_failed = 1'b1;
		end
		// (RULE20) lock cleared by erase
		if (erase_unlock_ev) begin
			state_d.lock = 1'b0;
		end

		// (RULE13) clear on read, live reset wins
		if (reg_rd && reg_addr == `OFS_ACCESS_STATUS) begin
			state_d.reset_seen = 1'b0;
		end
		if (system_reset_active_s || held_reset) begin
			state_d.reset_seen = 1'b1;
		end

		// (RULE23) key flag, start wins
		if (prog_key_set) begin
			state_d.prog_key = 1'b1;
		end
		if (pstart_s) begin
			state_d.prog_key = 1'b0;
		end

		// (RULE18) bus gate
		state_d.bus_ok = boot_s && !system_reset_active_s && !state_d.reset_out;

		// (RULE22) read port of the debug link only
		state_d.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`OFS_RESET_REQ:     state_d.rdata = state_q.reset_req;
				`OFS_CLOCK_CTRL:    state_d.rdata = {6'h00, state_q.clk_sel};
				`OFS_ACCESS_CTRL:   state_d.rdata = {7'h00, state_q.clk_req};
				`OFS_ACCESS_STATUS: state_d.rdata = status_w;
				// (RULE21) one-hot field read through
				`OFS_CRC_STATUS:    state_d.rdata = {5'h00, crc_status_in};
				default:            state_d.rdata = 8'h00;
			endcase
		end
	end

	// (RULE3) only the port reset clears this state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q              <= '0;
			state_q.reset_req    <= `RST_RESET_REQ;
			state_q.clk_sel      <= `RST_CLOCK_CTRL;
			state_q.lock         <= `RST_LOCK;
		end else begin
			state_q <= state_d;
		end
	end

	// (RULE2) reset held while code stands
	assign system_reset_req            = state_q.reset_out;
	assign system_clock_request        = state_q.clk_req;
	assign user_row_done               = state_q.urow_done;
	assign port_clock_divider_select   = state_q.clk_sel;
	assign bus_access_allowed          = state_q.bus_ok;
	assign memory_programming_key_flag = state_q.prog_key;
	assign reg_rdata                   = state_q.rdata;

	// assertions: reset request path
	reset_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE2)
		(system_reset_req && !(reg_wr && reg_addr == `OFS_RESET_REQ)) |=> system_reset_req)
		else $error("system reset dropped early");
	reset_code_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE1)
		(reg_wr && reg_addr == `OFS_RESET_REQ)
		|=> system_reset_req == ($past(reg_wdata) == `RESET_CODE))
		else $error("reset request code mismatch");
	run_code_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE1)
		(reg_wr && reg_addr == `OFS_RESET_REQ && reg_wdata == `RUN_CODE) |=> !system_reset_req)
		else $error("clear code left reset asserted");
	// the system reset must leave port configuration alone
	keep_config_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE3)
		(system_reset_req && !reg_wr && port_enable == state_q.enable_prev)
		|=> $stable(port_clock_divider_select) && $stable(system_clock_request))
		else $error("system reset disturbed port state");

	// configuration and defaults
	sel_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE4)
		port_clock_divider_select != 2'h0)
		else $error("reserved divider code held");
	reset_defaults_a: assert property (@(posedge clk) // (RULE5)
		!rst_n |=> port_clock_divider_select == 2'h3 && !system_clock_request && !system_reset_req)
		else $error("reset values wrong");
	urow_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE7)
		user_row_done |-> $past(urow_key_ok) && $past(reg_wr))
		else $error("user row start without key");
	// a second start write right behind the first would legally stretch the pulse
	urow_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE6)
		(reg_wr && reg_addr == `OFS_ACCESS_CTRL && urow_key_ok && reg_wdata[1])
		##1 !(reg_wr && reg_addr == `OFS_ACCESS_CTRL) |-> user_row_done ##1 !user_row_done)
		else $error("user row start not a pulse");
	clk_auto_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE10)
		$rose(port_enable) |=> system_clock_request && port_clock_divider_select == 2'h3)
		else $error("enable did not request clock");

	// status and access gate
	bus_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE18)
		bus_access_allowed |-> $past(boot_s) && !$past(system_reset_active_s) && !system_reset_req)
		else $error("bus allowed before boot");
	status_or_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE11)
		(reg_rd && reg_addr == `OFS_ACCESS_STATUS) |=> reg_rdata[7] == (reg_rdata[6] | reg_rdata[1]))
		else $error("status bit 7 wrong");
	sleep_track_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE14)
		(reg_rd && reg_addr == `OFS_ACCESS_STATUS) |=> reg_rdata[4] == $past(sleep_s))
		else $error("sleep flag wrong");
	crc_read_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE21)
		(reg_rd && reg_addr == `OFS_CRC_STATUS) |=> reg_rdata == {5'h00, $past(crc_status_in)})
		else $error("crc status read wrong");
	key_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE23)
		pstart_s |=> !memory_programming_key_flag)
		else $error("key flag not cleared");
	erase_fail_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE12)
		erase_fail_ev |=> state_q.erase_failed)
		else $error("erase fail lost");
	erase_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE12)
		(system_reset_active_s || held_reset) && !erase_fail_ev |=> !state_q.erase_failed)
		else $error("erase fail survived reset");
	reset_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE13)
		(system_reset_active_s || held_reset) |=> state_q.reset_seen)
		else $error("reset active flag lost");
	lock_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // (RULE20)
		erase_unlock_ev |=> !state_q.lock)
		else $error("lock flag not cleared");

	// cover points for the main scenarios
	reset_cycle_c: cover property (@(posedge clk) disable iff (!rst_n)
		system_reset_req ##[1:20] !system_reset_req);
	urow_start_c: cover property (@(posedge clk) disable iff (!rst_n) user_row_done);
	bus_open_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(bus_access_allowed));
	erase_set_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(state_q.erase_failed));
	key_drop_c: cover property (@(posedge clk) disable iff (!rst_n)
		$fell(memory_programming_key_flag));

endmodule

`default_nettype wire

// ===== tb/debugger_model.sv
`timescale 1ns/1ns
`default_nettype none

// debugger at the far end of the register port, one access per call
module debugger_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic [3:0]      reg_addr,
	output logic [7:0]      reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end

	// strobe held across one edge; idle lines scrambled so stale values never look valid
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// ===== tb/debug_port_system_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module debug_port_system_control_tb_top
	import sysacc_pkg::*;
;
	logic       clk, rst_n, port_enable, reg_wr, reg_rd, urow_key_ok, prog_key_set;
	logic       sys_reset_in, sys_sleep_in, boot_done_in, erase_fail_ev, erase_unlock_ev;
	logic       prog_start_in, urow_start_in, system_reset_req, system_clock_request;
	logic       user_row_done, bus_access_allowed, memory_programming_key_flag;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [2:0] crc_status_in;
	logic [1:0] port_clock_divider_select;
	int         n_errors, checks;

	system_access_regs dut_u (.clk(clk), .rst_n(rst_n), .port_enable(port_enable),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.urow_key_ok(urow_key_ok), .prog_key_set(prog_key_set), .sys_reset_in(sys_reset_in),
		.sys_sleep_in(sys_sleep_in), .boot_done_in(boot_done_in),
		.erase_fail_ev(erase_fail_ev), .erase_unlock_ev(erase_unlock_ev),
		.prog_start_in(prog_start_in), .urow_start_in(urow_start_in),
		.crc_status_in(crc_status_in), .reg_rdata(reg_rdata),
		.system_reset_req(system_reset_req), .system_clock_request(system_clock_request),
		.user_row_done(user_row_done), .port_clock_divider_select(port_clock_divider_select),
		.bus_access_allowed(bus_access_allowed),
		.memory_programming_key_flag(memory_programming_key_flag));

	debugger_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic test_done;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		host_u.xfer(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host_u.xfer(1'b0, a, 8'h00, q);
		chk(what, exp, q);
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	// status inputs pass a three-stage synchroniser, so give them time
	task automatic settle;
		repeat (6) @(negedge clk);
	endtask

	task automatic t_reset_values;
		rd_chk("reset_req", 4'h8, 8'h00);
		rd_chk("clock_ctrl", 4'h9, 8'h03);
		rd_chk("status", 4'hb, 8'h01);
		rd_chk("access_ctrl", 4'ha, 8'h00);
	endtask

	task automatic t_enable_urow;
		port_enable = 1'b1;
		settle();
		chk("clock_req", 8'h01, {7'h0, system_clock_request});
		wr(4'ha, 8'h00);
		chk("clock_req", 8'h00, {7'h0, system_clock_request});
		wr(4'ha, 8'h03);
		chk("urow_done", 8'h00, {7'h0, user_row_done});
		urow_key_ok = 1'b1;
		// user row data assumed already in ram before this write
		wr(4'ha, 8'h03);
		chk("urow_done", 8'h01, {7'h0, user_row_done});
		@(negedge clk);
		chk("urow_done", 8'h00, {7'h0, user_row_done});
		rd_chk("access_ctrl", 4'ha, 8'h01);
	endtask

	task automatic t_divider;
		logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h00, 8'h02};
		logic [7:0] exp;
		exp = 8'h03;
		foreach (codes[i]) begin
			wr(4'h9, codes[i]);
			if (codes[i] != 8'h00) exp = codes[i];
			rd_chk("clock_ctrl", 4'h9, exp);
			chk("divider", exp, {6'h0, port_clock_divider_select});
		end
	endtask

	task automatic t_sys_reset;
		pulse(erase_fail_ev);
		rd_chk("status", 4'hb, 8'hc1);
		wr(4'h8, 8'h59);
		chk("reset_req", 8'h01, {7'h0, system_reset_req});
		rd_chk("status", 4'hb, 8'h21);
		rd_chk("status", 4'hb, 8'h21);
		rd_chk("clock_ctrl", 4'h9, 8'h02);
		chk("reset_req", 8'h01, {7'h0, system_reset_req});
		wr(4'h8, 8'h00);
		chk("reset_req", 8'h00, {7'h0, system_reset_req});
		rd_chk("status", 4'hb, 8'h21);
		rd_chk("status", 4'hb, 8'h01);
	endtask

	task automatic t_status;
		logic [2:0] crc [4] = '{CRC_OFF, CRC_BUSY, CRC_OK, CRC_FAIL};
		pulse(prog_key_set);
		chk("key_flag", 8'h01, {7'h0, memory_programming_key_flag});
		chk("bus_ok", 8'h00, {7'h0, bus_access_allowed});
		{sys_sleep_in, prog_start_in, urow_start_in, boot_done_in} = 4'hf;
		settle();
		// boot done and no system reset confirmed before bus use
		rd_chk("status", 4'hb, 8'h9f);
		chk("bus_ok", 8'h01, {7'h0, bus_access_allowed});
		chk("key_flag", 8'h00, {7'h0, memory_programming_key_flag});
		sys_reset_in = 1'b1;
		settle();
		rd_chk("status", 4'hb, 8'hbf);
		chk("bus_ok", 8'h00, {7'h0, bus_access_allowed});
		sys_reset_in = 1'b0;
		settle();
		rd_chk("status", 4'hb, 8'hbf);
		chk("bus_ok", 8'h01, {7'h0, bus_access_allowed});
		pulse(erase_unlock_ev);
		rd_chk("status", 4'hb, 8'h9e);
		foreach (crc[i]) begin
			crc_status_in = crc[i];
			rd_chk("crc", 4'hc, {5'h0, crc[i]});
		end
		rd_chk("unmapped", 4'h3, 8'h00);
		// programming over, debugger resets the system
		wr(4'h8, 8'h59);
		chk("reset_req", 8'h01, {7'h0, system_reset_req});
		chk("bus_ok", 8'h00, {7'h0, bus_access_allowed});
	endtask

	// watchdog: the sequence needs about a hundred cycles
	initial begin
		#(5000 * 50);
		n_errors++;
		test_done();
	end

	initial begin
		n_errors = 0;
		checks = 0;
		rst_n = 1'b0;
		{port_enable, urow_key_ok, prog_key_set, sys_reset_in, sys_sleep_in} = 5'h00;
		{boot_done_in, erase_fail_ev, erase_unlock_ev, prog_start_in} = 4'h0;
		urow_start_in = 1'b0;
		crc_status_in = 3'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_reset_values();
		t_enable_urow();
		t_divider();
		t_sys_reset();
		t_status();
		test_done();
	end
endmodule
`default_nettype wire
